// [rtl/complex_multiply_accumulator_pkg.sv]
package complex_multiply_accumulator_pkg;
  // operand and datapath widths
  localparam int IN_W      = 16;  // sin, cos and sample width
  localparam int SHX_W     = 19;  // sign-extended latch seen by shifter
  localparam int PROD_W    = 33;  // complex multiplier result
  localparam int COMPLEX_MULTIPLY_ACCUMULATOR_W    = 35;  // multiplier accumulator, bits 0..34
  localparam int CA_W      = 20;  // complex accumulator
  localparam int OUT_W     = 20;  // output port width
  localparam int DET_W     = 2;   // growth code width
  // output field positions inside the multiplier accumulator
  localparam int CM_FLD_LSB = 15; // output bit 0 for select 00
  localparam int CM_HI_LSB  = 31; // output bits 16..19 source
  localparam int CA_PT_BIT  = 15; // 2^0 position of 20-bit outputs
  // output select codes
  localparam logic [1:0] OSEL_COMPLEX_MULTIPLY_ACCUMULATOR_HI = 2'h0;
  localparam logic [1:0] OSEL_COMPLEX_MULTIPLY_ACCUMULATOR_LO = 2'h1;
  localparam logic [1:0] OSEL_ACC     = 2'h2;
  // rounding control register
  localparam logic [1:0] RC_ADDR     = 2'h3;
  localparam int         RC_ACC_LSB  = 0;
  localparam int         RC_COMPLEX_MULTIPLY_ACCUMULATOR_LSB = 4;
  localparam int         RC_FLD_W    = 4;
  localparam logic [7:0] RC_RESET    = 8'h00;
  localparam logic [3:0] RND_MAX     = 4'hC;
  localparam logic [5:0] CM_RND_OFS  = 6'h0D; // code n adds at bit n+13
  // host pin synchroniser width and buffer depth
  localparam int SYNC_W     = 20;  // strobe, select, register, 16 data
  localparam int FIFO_DEPTH = 32;
  localparam int WORD_W     = DET_W + 2 * OUT_W;
endpackage : complex_multiply_accumulator_pkg

// [rtl/complex_mult_accum_round.sv]
`timescale 1ns/100ps

// output buffer: registered array, honest full and empty
module out_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];   // storage words
  logic [AW:0]  wr_ptr_r;      // extra bit tells full from empty
  logic [AW:0]  rd_ptr_r;
  wire          full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                        (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire          empty = (wr_ptr_r == rd_ptr_r);
  wire          push  = in_valid_in && !full;
  wire          pop   = out_ready_in && !empty;

  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rd_ptr_r[AW-1:0]];

  // storage has no reset, pointers guard it
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  // pointer update
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  fifo_nofill_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    full && !pop |=> $stable(wr_ptr_r))
    else $error("fifo pointer moved while full");

  fifo_noempty_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    empty |=> $stable(rd_ptr_r))
    else $error("fifo read pointer moved while empty");
endmodule : out_fifo

module complex_mult_accum_round
  import complex_multiply_accumulator_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  nrst_in,
  input  wire logic signed [IN_W-1:0] cos_in,
  input  wire logic signed [IN_W-1:0] sin_in,
  input  wire logic [IN_W-1:0]       real_input_in,
  input  wire logic [IN_W-1:0]       imag_input_in,
  input  wire logic                  input_load_enable_n_in,
  input  wire logic [1:0]            input_shift_select_in,
  input  wire logic                  accumulate_enable_in,
  input  wire logic [1:0]            output_select_in,
  input  wire logic                  number_format_select_in,
  input  wire logic                  peak_hold_n_in,
  input  wire logic                  round_enable_n_in,
  input  wire logic [15:0]           control_word_bus_in,
  input  wire logic [1:0]            register_select_in,
  input  wire logic                  chip_select_n_in,
  input  wire logic                  write_strobe_n_in,
  output logic                       sample_ready_out,
  output logic                       out_valid_out,
  input  wire logic                  out_ready_in,
  output logic [OUT_W-1:0]           real_output_out,
  output logic [OUT_W-1:0]           imag_output_out,
  output logic [DET_W-1:0]           growth_code_out
);
  // pipeline advance: the buffer's ready stalls every stage
  logic adv;
  logic run_r;                 // push enable, high from the first clock after reset release on

  // host write port synchroniser, three stages
  logic [SYNC_W-1:0] s1_r;     // first stage, read only by s2_r
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic              wr_lvl_r; // accepted strobe level
  logic [7:0]        rc_r;     // rounding control, upper byte dropped

  wire [SYNC_W-1:0] pins = {write_strobe_n_in, chip_select_n_in,
                            register_select_in, control_word_bus_in};
  wire wr_agree  = (s2_r[19] == s3_r[19]);
  wire wr_rise   = wr_agree && s3_r[19] && !wr_lvl_r;
  wire rc_write  = wr_rise && !s3_r[18] && (s3_r[17:16] == RC_ADDR);

  // all host pins pass the same chain so they stay aligned
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_r     <= '1;
      s2_r     <= '1;
      s3_r     <= '1;
      wr_lvl_r <= 1'b1;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (wr_agree) wr_lvl_r <= s3_r[19];
    end
  end

  // control word latch on the strobe's rising edge
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rc_r <= RC_RESET;
    end else if (rc_write) begin
      rc_r <= s3_r[7:0];
    end
  end

  rc_write_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !rc_write |=> $stable(rc_r))
    else $error("round control changed without a write");

  // input registers
  logic [IN_W-1:0] in_r [2];   // 0 real, 1 imaginary
  wire             load = adv && !input_load_enable_n_in;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_r[0] <= '0;
      in_r[1] <= '0;
    end else if (load) begin
      in_r[0] <= real_input_in;
      in_r[1] <= imag_input_in;
    end
  end

  load_hold_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !load |=> $stable(in_r[0]) && $stable(in_r[1]))
    else $error("input register changed without load enable");

  // rounding codes, shared by both channels so precision matches
  wire [3:0] cm_code = rc_r[RC_COMPLEX_MULTIPLY_ACCUMULATOR_LSB +: RC_FLD_W];
  wire [3:0] ca_code = rc_r[RC_ACC_LSB +: RC_FLD_W];
  wire       cm_on   = !round_enable_n_in && (cm_code != 4'h0) &&
                       (cm_code <= RND_MAX);
  wire       ca_on   = !round_enable_n_in && (ca_code != 4'h0) &&
                       (ca_code <= RND_MAX);
  // code n keeps top 21-n bits; half an lsb is added below them
  wire [5:0] cm_pos  = {2'h0, cm_code} + CM_RND_OFS;
  wire [COMPLEX_MULTIPLY_ACCUMULATOR_W-1:0] cm_add  = cm_on ? (COMPLEX_MULTIPLY_ACCUMULATOR_W'(1) << cm_pos) : '0;
  wire [COMPLEX_MULTIPLY_ACCUMULATOR_W-1:0] cm_mask = cm_on ? ~((COMPLEX_MULTIPLY_ACCUMULATOR_W'(1) << (cm_pos + 6'h1))
                                        - COMPLEX_MULTIPLY_ACCUMULATOR_W'(1)) : '1;
  // at code 1 the bit below the field lies outside the accumulator
  wire [CA_W-1:0] ca_add  = (ca_on && ca_code > 4'h1) ?
                            (CA_W'(1) << (ca_code - 4'h2)) : '0;
  wire [CA_W-1:0] ca_mask = ca_on ? ~((CA_W'(1) << (ca_code - 4'h1))
                                      - CA_W'(1)) : '1;

  // per-channel datapath
  logic signed [IN_W-1:0]   sh   [2];  // shifter outputs
  logic signed [PROD_W-1:0] mreg_r [2];
  logic signed [COMPLEX_MULTIPLY_ACCUMULATOR_W-1:0] complex_multiply_accumulator_r [2];
  logic signed [CA_W-1:0]   ca_r [2];
  logic [OUT_W-1:0]         fld  [2];  // selected, rounded field
  logic [OUT_W-1:0]         outv [2];  // after format inversion
  logic [DET_W-1:0]         g_cm [2];
  logic [DET_W-1:0]         g_ca [2];

  // growth of a sign plus four integer bits, 2^3 down to 2^0
  function automatic logic [DET_W-1:0] growth(input logic [4:0] t);
    if (t[4:0] == '0 || t[4:0] == '1)      return 2'h0;
    else if (t[4:1] == '0 || t[4:1] == '1) return 2'h1;
    else if (t[4:2] == '0 || t[4:2] == '1) return 2'h2;
    else                                   return 2'h3;
  endfunction : growth

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    // arithmetic view of the latch: sign bits fill above bit 15
    wire [SHX_W-1:0] ext = {{(SHX_W-IN_W){in_r[ch][IN_W-1]}}, in_r[ch]};
    assign sh[ch] = ext[input_shift_select_in +: IN_W];
    // inputs and sin/cos are 1.15, so products are 2.30
    wire signed [2*IN_W-1:0] p_cos = cos_in * sh[ch];
    wire signed [2*IN_W-1:0] p_sin = sin_in * sh[1-ch];
    wire signed [PROD_W-1:0] prod  = (ch == 0) ?
      (PROD_W'(p_cos) - PROD_W'(p_sin)) :
      (PROD_W'(p_cos) + PROD_W'(p_sin));
    // feedback is forced to zero to dump
    wire signed [COMPLEX_MULTIPLY_ACCUMULATOR_W-1:0] cm_fb = accumulate_enable_in ? complex_multiply_accumulator_r[ch] : '0;
    wire signed [CA_W-1:0]   ca_fb = accumulate_enable_in ? ca_r[ch] : '0;
    wire [COMPLEX_MULTIPLY_ACCUMULATOR_W-1:0] cm_rnd = (complex_multiply_accumulator_r[ch] + cm_add) & cm_mask;
    wire [CA_W-1:0]   ca_rnd = (ca_r[ch] + ca_add) & ca_mask;

    // multiplier and accumulator registers
    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        mreg_r[ch] <= '0;
        complex_multiply_accumulator_r[ch] <= '0;
        ca_r[ch]   <= '0;
      end else if (adv) begin
        mreg_r[ch] <= prod;
        complex_multiply_accumulator_r[ch] <= cm_fb + COMPLEX_MULTIPLY_ACCUMULATOR_W'(mreg_r[ch]);
        ca_r[ch]   <= ca_fb + CA_W'(sh[ch]);
      end
    end

    // field select; code 11 drives zero
    assign fld[ch] =
      (output_select_in == OSEL_COMPLEX_MULTIPLY_ACCUMULATOR_HI) ? cm_rnd[CM_FLD_LSB +: OUT_W] :
      (output_select_in == OSEL_COMPLEX_MULTIPLY_ACCUMULATOR_LO) ?
        {complex_multiply_accumulator_r[ch][CM_HI_LSB +: 4], 1'b0, complex_multiply_accumulator_r[ch][CM_FLD_LSB-1:0]} :
      (output_select_in == OSEL_ACC) ? ca_rnd : '0;
    // inversion after rounding keeps the round on signed data
    assign outv[ch] = {fld[ch][OUT_W-1] ^ !number_format_select_in,
                       fld[ch][OUT_W-2:0]};
    assign g_cm[ch] = growth(complex_multiply_accumulator_r[ch][COMPLEX_MULTIPLY_ACCUMULATOR_W-1 -: 5]);
    assign g_ca[ch] = growth(ca_r[ch][CA_W-1 -: 5]);
  end

  shift_sel_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    sh[0] == IN_W'($signed(in_r[0]) >>> input_shift_select_in))
    else $error("shifter picked the wrong bits");

  product_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    adv |=> mreg_r[0] == PROD_W'($past(cos_in) * $past(sh[0]))
                       - PROD_W'($past(sin_in) * $past(sh[1])))
    else $error("real product register wrong");

  dump_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    adv && !accumulate_enable_in |=>
      complex_multiply_accumulator_r[1] == COMPLEX_MULTIPLY_ACCUMULATOR_W'($past(mreg_r[1])))
    else $error("dump kept accumulator feedback");

  acc_sum_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    adv && accumulate_enable_in |=>
      ca_r[0] == CA_W'($past(ca_r[0]) + CA_W'($past(sh[0]))))
    else $error("complex accumulator did not add");

  // top bit kept for two's complement, flipped for unsigned
  fmt_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (outv[0][OUT_W-1] == fld[0][OUT_W-1]) == number_format_select_in)
    else $error("output top bit format wrong");

  no_round_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    round_enable_n_in && output_select_in == OSEL_ACC |->
      fld[1] == ca_r[1])
    else $error("rounding applied while disabled");

  // code 2 keeps nineteen bits: half an lsb lands on field bit 0
  cm_round_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !round_enable_n_in && output_select_in == OSEL_COMPLEX_MULTIPLY_ACCUMULATOR_HI &&
      cm_code == 4'h2 |->
      fld[0] == {complex_multiply_accumulator_r[0][COMPLEX_MULTIPLY_ACCUMULATOR_W-1:CM_FLD_LSB+1]
                 + (OUT_W-1)'(complex_multiply_accumulator_r[0][CM_FLD_LSB]), 1'b0})
    else $error("multiplier rounding to nineteen bits wrong");

  // code 1 keeps all twenty accumulator bits, nothing to add
  ca_round_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !round_enable_n_in && output_select_in == OSEL_ACC &&
      ca_code == 4'h1 |-> fld[1] == ca_r[1])
    else $error("accumulator code one changed the field");

  // a value between one and two carries one bit of growth
  growth_one_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    complex_multiply_accumulator_r[0][COMPLEX_MULTIPLY_ACCUMULATOR_W-1 -: 4] == 4'h0 && complex_multiply_accumulator_r[0][COMPLEX_MULTIPLY_ACCUMULATOR_W-5] |->
      g_cm[0] == 2'h1)
    else $error("growth code wrong for one integer bit");

  // growth detect, worst of both sources and channels
  logic [DET_W-1:0] det_r;
  wire  [DET_W-1:0] g_a   = (g_cm[0] > g_cm[1]) ? g_cm[0] : g_cm[1];
  wire  [DET_W-1:0] g_b   = (g_ca[0] > g_ca[1]) ? g_ca[0] : g_ca[1];
  wire  [DET_W-1:0] g_now = (g_a > g_b) ? g_a : g_b;
  wire  [DET_W-1:0] det_nxt = (!peak_hold_n_in && det_r > g_now) ?
                              det_r : g_now;

  // growth register and push enable
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      det_r <= '0;
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
      if (adv) det_r <= det_nxt;
    end
  end

  peak_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    adv && !peak_hold_n_in |=> det_r >= $past(det_r))
    else $error("peak hold lost a larger growth code");

  det_free_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    adv && peak_hold_n_in |=> det_r == $past(g_now))
    else $error("growth register did not follow live growth");

  // output buffer; its ready stalls the whole datapath
  logic             fifo_ready;
  logic [WORD_W-1:0] fifo_out;
  assign adv              = fifo_ready;
  assign sample_ready_out = fifo_ready;

  out_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (run_r),
    .in_ready_out  (fifo_ready),
    .in_data_in    ({det_r, outv[0], outv[1]}),
    .out_valid_out (out_valid_out),
    .out_ready_in  (out_ready_in),
    .out_data_out  (fifo_out)
  );

  assign growth_code_out = fifo_out[WORD_W-1 -: DET_W];
  assign real_output_out = fifo_out[2*OUT_W-1 -: OUT_W];
  assign imag_output_out = fifo_out[OUT_W-1:0];
endmodule : complex_mult_accum_round

// [tb/far_side_model.sv]
`timescale 1ns/100ps
// far side: vector generator plus a filter that drains the block
module far_side_model (
  input  wire logic        mclk_in,    // bench clock
  input  wire logic [15:0] cos_req_in, // cosine asked for
  input  wire logic [15:0] sin_req_in, // sine asked for
  input  wire logic        stall_in,   // filter busy
  input  wire logic        valid_in,   // word offered
  input  wire logic [19:0] word_in,    // real word offered
  output logic [15:0]      cos_out,    // vector to the block
  output logic [15:0]      sin_out,
  output logic             ready_out   // filter takes the word
);
  logic [19:0] seen[$]; // taken real words, oldest first
  // range is symmetric, so the code 8000 never leaves the generator
  assign cos_out = (cos_req_in == 16'h8000) ? 16'h8001 : cos_req_in;
  assign sin_out = (sin_req_in == 16'h8000) ? 16'h8001 : sin_req_in;
  assign ready_out = !stall_in;
  // log every word the filter takes
  always @(posedge mclk_in) begin
    if (valid_in && ready_out) begin
      seen.push_back(word_in);
    end
  end
endmodule : far_side_model

// [tb/complex_mult_accum_round_bench.sv]
`timescale 1ns/100ps
module complex_mult_accum_round_bench;
  import complex_multiply_accumulator_pkg::*;
  logic        mclk_in = 1'b0, nrst_in = 1'b0;  // reset low at start
  logic [15:0] cq = 16'h0000, sq = 16'h0000;    // vector asked for
  logic [15:0] cosv, sinv, re = 16'h0000, im = 16'h0000, cw = 16'h0000;
  logic [1:0]  sh = 2'h0, osel = 2'h0, rs = 2'h0, gc;
  logic        ld_n = 1'b1, acc = 1'b0, fmt = 1'b1, rnd_n = 1'b1, pk_n = 1'b1;
  logic        cs_n = 1'b1, wr_n = 1'b1, stall = 1'b0, found;
  logic        srdy, ov, ordy;
  logic [19:0] ro, io, er, ei;                  // seen and expected
  logic [31:0] lfsr_r = 32'h88398689;           // fixed seed
  int          rc_cm = 0, rc_acc = 0;           // model rounding codes
  int          error_cnt = 0, total_checks = 0;
  complex_mult_accum_round dut_u (
    .mclk_in, .nrst_in, .cos_in(cosv), .sin_in(sinv),
    .real_input_in(re), .imag_input_in(im),
    .input_load_enable_n_in(ld_n), .input_shift_select_in(sh),
    .accumulate_enable_in(acc), .output_select_in(osel),
    .number_format_select_in(fmt), .peak_hold_n_in(pk_n),
    .round_enable_n_in(rnd_n), .control_word_bus_in(cw),
    .register_select_in(rs), .chip_select_n_in(cs_n),
    .write_strobe_n_in(wr_n), .sample_ready_out(srdy),
    .out_valid_out(ov), .out_ready_in(ordy), .real_output_out(ro),
    .imag_output_out(io), .growth_code_out(gc));
  far_side_model partner_u (
    .mclk_in, .cos_req_in(cq), .sin_req_in(sq), .stall_in(stall),
    .valid_in(ov), .word_in(ro), .cos_out(cosv), .sin_out(sinv),
    .ready_out(ordy));
  always #5 mclk_in = ~mclk_in; // 10 ns period
  // sixteen shifts per draw so successive words differ well
  function automatic logic [31:0] rnd();
    repeat (16) lfsr_r = {lfsr_r[30:0], ^(lfsr_r & 32'h80200003)};
    return lfsr_r;
  endfunction : rnd
  // wait n edges, then 1 ns past the last one
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : cyc
  task automatic chk(string nm, logic [19:0] e, logic [19:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_flag(string nm, logic e, logic g);
    chk(nm, {19'h00000, e}, {19'h00000, g});
  endtask : chk_flag
  // host write: strobe low 4 cycles, rise, let the sync settle
  task automatic wr(logic [15:0] d, logic [1:0] a, logic c);
    cw = d;
    rs = a;
    cs_n = c;
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cyc(6);
    if (a == RC_ADDR && !c) begin
      rc_acc = d[3:0];
      rc_cm = d[7:4];
    end
  endtask : wr
  // one channel of the expected word, from the latched sample
  function automatic logic [19:0] model(logic imc);
    logic signed [18:0] xr, xi;
    longint c, s, r, i, p;
    logic [34:0] m;
    logic [19:0] f;
    xr = $signed(re) >>> sh;
    xi = $signed(im) >>> sh;
    r = $signed(xr[15:0]);
    i = $signed(xi[15:0]);
    c = $signed(cosv);
    s = $signed(sinv);
    p = imc ? c * i + s * r : c * r - s * i;
    m = p[34:0];
    case (osel)
      2'h0: begin
        if (!rnd_n && rc_cm >= 1 && rc_cm <= 12) begin
          m = m + (35'h1 << (rc_cm + 13));
          m = m & ~((35'h1 << (rc_cm + 14)) - 35'h1);
        end
        f = m[34:15];
      end
      2'h1: f = {m[34:31], 1'b0, m[14:0]};
      2'h2: begin
        f = imc ? i[19:0] : r[19:0];
        if (!rnd_n && rc_acc >= 2 && rc_acc <= 12) begin
          f = f + (20'h1 << (rc_acc - 2));
          f = f & ~((20'h1 << (rc_acc - 1)) - 20'h1);
        end
      end
      default: f = 20'h00000; // reserved code shows zero
    endcase
    f[19] = f[19] ^ !fmt;
    return f;
  endfunction : model
  // random vector and sample, then a reload that must be ignored
  task automatic run_case(logic [1:0] s);
    logic [31:0] v;
    v = rnd();
    cq = v[15:0];
    sq = v[31:16];
    v = rnd();
    re = v[15:0];
    im = v[31:16];
    v = rnd();
    sh = v[1:0];
    fmt = v[2];
    osel = s;
    ld_n = 1'b0;
    cyc(45); // buffer may lag by up to 32 words
    er = model(1'b0);
    ei = model(1'b1);
    chk("real word", er, ro);
    chk("imag word", ei, io);
    ld_n = 1'b1;
    re = ~re;
    im = ~im;
    cyc(45);
    chk("held word", er, ro);
  endtask : run_case
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog, far past the ~7200 cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    #1;
    chk_flag("valid in reset", 1'b0, ov);
    nrst_in = 1'b1;
    cyc(2);
    // every code against every select, each after a refused write
    for (int k = 0; k < 64; k++) begin
      wr(16'(rnd()), 2'(k), 1'(k % 4 == 3));
      wr({8'(rnd()), 4'(k / 4), 4'(15 - k / 4)}, RC_ADDR, 1'b0);
      rnd_n = (k % 5 == 4);
      run_case(2'(k));
    end
    $display("test rounding sweep done");
    // steady product of 80, then two cycles of accumulation
    cq = 16'h4000;
    sq = 16'h0000; // no cross terms, so the product is cos times re alone
    re = 16'h0100;
    im = 16'h0000;
    sh = 2'h0;
    osel = OSEL_COMPLEX_MULTIPLY_ACCUMULATOR_HI;
    fmt = 1'b1;
    rnd_n = 1'b1;
    ld_n = 1'b0;
    cyc(45);
    partner_u.seen.delete();
    acc = 1'b1;
    cyc(2);
    acc = 1'b0;
    cyc(50);
    found = 1'b0;
    foreach (partner_u.seen[n]) begin
      if (n >= 2 && {partner_u.seen[n - 2], partner_u.seen[n - 1],
          partner_u.seen[n]} == 60'h000800010000180) begin
        found = 1'b1;
      end
    end
    chk_flag("sum run", 1'b1, found);
    $display("test accumulate done");
    // growth: real multiplier sum climbs to about 4.5, accumulator to about nine, held, then freed
    re = 16'h7FFF;
    pk_n = 1'b0;
    cyc(10);
    chk("growth idle", 20'h00000, {18'h00000, gc});
    acc = 1'b1;
    cyc(8);
    acc = 1'b0;
    cyc(10);
    chk("growth held", 20'h00003, {18'h00000, gc});
    pk_n = 1'b1;
    cyc(10);
    chk("growth freed", 20'h00000, {18'h00000, gc});
    $display("test growth done");
    // filter stalls until the buffer refuses
    stall = 1'b1;
    cyc(40);
    chk_flag("ready when full", 1'b0, srdy);
    chk_flag("valid when full", 1'b1, ov);
    stall = 1'b0;
    cyc(2);
    chk_flag("ready after pop", 1'b1, srdy);
    $display("test buffer fill done");
    tally_and_finish();
  end
endmodule : complex_mult_accum_round_bench
